// File: core/fth_consts.vh
// register offsets, field positions, reset values and duty codes for the thermal override block
`ifndef FTH_CONSTS_VH
`define FTH_CONSTS_VH
`define FTH_ADDR_KEEP_SPIN     8'h62
`define FTH_ADDR_R1_CRIT       8'h6a
`define FTH_ADDR_LOC_CRIT      8'h6b
`define FTH_ADDR_R2_CRIT       8'h6c
`define FTH_ADDR_R1_LOC_HYST   8'h6d
`define FTH_ADDR_R2_HYST       8'h6e
`define FTH_ADDR_STATUS        8'h70
`define FTH_ADDR_R1_FAN_ON     8'h71
`define FTH_ADDR_LOC_FAN_ON    8'h72
`define FTH_ADDR_R2_FAN_ON     8'h73
`define FTH_ADDR_MIN_DUTY1     8'h74
`define FTH_ADDR_MIN_DUTY2     8'h75
`define FTH_ADDR_MIN_DUTY3     8'h76
`define FTH_CRIT_RST           8'ha4
`define FTH_HYST_RST           4'h4
`define FTH_R1_LOC_HYST_RST    8'h44
`define FTH_R2_HYST_RST        8'h40
`define FTH_KEEP_SPIN_RST      8'h00
`define FTH_FAN_ON_RST         8'h5a
`define FTH_MIN_DUTY_RST       8'h80
`define FTH_KEEP_SPIN1_BIT     5
`define FTH_KEEP_SPIN2_BIT     6
`define FTH_KEEP_SPIN3_BIT     7
`define FTH_HYST_HI_MSB        7
`define FTH_HYST_HI_LSB        4
`define FTH_HYST_LO_MSB        3
`define FTH_HYST_LO_LSB        0
`define FTH_DUTY_FULL          8'hff
`define FTH_DUTY_OFF           8'h00
`endif

// File: core/fth_override.v
// thermal override, fan on/off hysteresis and register file of the fan controller
// Functional notes
// R1 - Any channel temperature above its critical limit forces every fan output to full duty.
// R2 - Full duty holds until that channel falls below its critical limit minus its hysteresis.
// R3 - Every hysteresis field resets to four degrees.
// R4 - The critical override cannot be masked and beats every automatic fan setting.
// R5 - Three 8-bit critical limits (remote 1, local, remote 2) each reset to 0xa4, 100 degrees.
// R6 - The first hysteresis register holds remote 1 in bits 7:4 and local in bits 3:0.
// R7 - The second hysteresis register holds remote 2 in bits 7:4.
// R8 - Each hysteresis is a 4-bit unsigned count of one-degree steps, 1 to 15.
// R9 - Software should not program zero hysteresis; zero simply removes the hysteresis band.
// R10 - Once below fan-on temperature, a fan keeps running until below fan-on minus hysteresis.
// R11 - One hysteresis field per channel serves both fan turn-off and override release.
// R12 - Keep-spin bits 7, 6, 5 belong to outputs 3, 2, 1; clear means zero duty when off.
// R13 - A set keep-spin bit runs that output at its minimum duty instead of zero when off.
// R14 - For a keep-spinning output the hysteresis has no effect on its off behaviour.
// R15 - Override full duty is code 255.
// R16 - Override is tracked per channel and re-evaluated on each new reading.
`timescale 1ns/1ps
`include "fth_consts.vh"
module fth_override
(
	input  wire       I_CLK,
	input  wire       I_RST_N,
	input  wire [7:0] I_ADDR,
	input  wire [7:0] I_WDATA,
	input  wire       I_WR,
	input  wire       I_RD,
	output wire [7:0] O_RDATA,
	input  wire [7:0] I_TEMP_R1,
	input  wire [7:0] I_TEMP_LOC,
	input  wire [7:0] I_TEMP_R2,
	input  wire       I_TEMP_VALID,
	input  wire [7:0] I_AUTO_DUTY_1,
	input  wire [7:0] I_AUTO_DUTY_2,
	input  wire [7:0] I_AUTO_DUTY_3,
	output wire [7:0] O_FAN_DRIVE_1,
	output wire [7:0] O_FAN_DRIVE_2,
	output wire [7:0] O_FAN_DRIVE_3,
	output wire       O_OVERRIDE
);

	reg  [7:0] keep_spin_ff;
	reg  [7:0] crit_r1_ff;
	reg  [7:0] crit_loc_ff;
	reg  [7:0] crit_r2_ff;
	reg  [7:0] hyst_r1_loc_ff;
	reg  [7:0] hyst_r2_ff;
	reg  [7:0] fan_on_r1_ff;
	reg  [7:0] fan_on_loc_ff;
	reg  [7:0] fan_on_r2_ff;
	reg  [7:0] min_duty1_ff;
	reg  [7:0] min_duty2_ff;
	reg  [7:0] min_duty3_ff;
	reg  [2:0] ovr_ff;
	reg  [2:0] run_ff;
	reg  [2:0] above_ff;
	reg  [7:0] rdata_ff;
	reg  [7:0] drive1_ff;
	reg  [7:0] drive2_ff;
	reg  [7:0] drive3_ff;
	reg  [7:0] nxt_rdata;
	wire [3:0] hyst_r1;
	wire [3:0] hyst_loc;
	wire [3:0] hyst_r2;
	wire [2:0] nxt_ovr;
	wire [2:0] nxt_run;
	wire [2:0] nxt_above;
	wire [2:0] keep_spin;
	wire [7:0] status_word;
	wire [7:0] nxt_drive1;
	wire [7:0] nxt_drive2;
	wire [7:0] nxt_drive3;
	wire       any_ovr;

	// strictly above limit; a reading equal to the limit does not trip
	function over_limit;
		input [7:0] temp;
		input [7:0] limit;
		begin
			over_limit = temp > limit;
		end
	endfunction

	// below limit minus hysteresis, done in 9 bits so low limits do not wrap
	function below_band;
		input [7:0] temp;
		input [7:0] limit;
		input [3:0] hyst;
		begin
			below_band = ({1'b0, temp} + {5'h00, hyst}) < {1'b0, limit};
		end
	endfunction

	// latch with hysteresis: set above limit, clear below limit minus hysteresis
	function hyst_latch;
		input       state;
		input [7:0] temp;
		input [7:0] limit;
		input [3:0] hyst;
		begin
			if (over_limit(temp, limit))
				hyst_latch = 1'b1;
			else if (below_band(temp, limit, hyst))
				hyst_latch = 1'b0;
			else
				hyst_latch = state;
		end
	endfunction

	// a kept-spinning fan drops to minimum once it is not above fan-on, so the
	// hysteresis band never shows on it; other fans stop only below the band
	function [7:0] fan_duty;
		input       ovr;
		input       run;
		input       above;
		input       spin;
		input [7:0] auto_duty;
		input [7:0] min_duty;
		begin
			if (ovr)
				fan_duty = `FTH_DUTY_FULL; // R1 R4 R15
			else if (spin)
				fan_duty = above ? auto_duty : min_duty; // R13 R14
			else
				fan_duty = run ? auto_duty : `FTH_DUTY_OFF; // R12
		end
	endfunction

	// one 4-bit band per channel, shared by fan-on and override release
	assign hyst_r1  = hyst_r1_loc_ff[`FTH_HYST_HI_MSB:`FTH_HYST_HI_LSB]; // R6
	assign hyst_loc = hyst_r1_loc_ff[`FTH_HYST_LO_MSB:`FTH_HYST_LO_LSB]; // R6
	assign hyst_r2  = hyst_r2_ff[`FTH_HYST_HI_MSB:`FTH_HYST_HI_LSB]; // R7

	// zero hysteresis collapses the band; no guard, software is told not to use it
	assign nxt_ovr[0] = hyst_latch(ovr_ff[0], I_TEMP_R1, crit_r1_ff, hyst_r1); // R2 R8 R9 R11
	assign nxt_ovr[1] = hyst_latch(ovr_ff[1], I_TEMP_LOC, crit_loc_ff, hyst_loc); // R2 R11
	assign nxt_ovr[2] = hyst_latch(ovr_ff[2], I_TEMP_R2, crit_r2_ff, hyst_r2); // R2 R11
	// fan-on state reuses the same band as the override release
	assign nxt_run[0] = hyst_latch(run_ff[0], I_TEMP_R1, fan_on_r1_ff, hyst_r1); // R10 R11
	assign nxt_run[1] = hyst_latch(run_ff[1], I_TEMP_LOC, fan_on_loc_ff, hyst_loc); // R10 R11
	assign nxt_run[2] = hyst_latch(run_ff[2], I_TEMP_R2, fan_on_r2_ff, hyst_r2); // R10 R11

	// above fan-on with no band, used only by kept-spinning fans
	assign nxt_above[0] = over_limit(I_TEMP_R1, fan_on_r1_ff); // R14
	assign nxt_above[1] = over_limit(I_TEMP_LOC, fan_on_loc_ff); // R14
	assign nxt_above[2] = over_limit(I_TEMP_R2, fan_on_r2_ff); // R14

	// only bits 7:5 steer the fans; the rest is plain storage
	assign keep_spin[0] = keep_spin_ff[`FTH_KEEP_SPIN1_BIT]; // R12
	assign keep_spin[1] = keep_spin_ff[`FTH_KEEP_SPIN2_BIT]; // R12
	assign keep_spin[2] = keep_spin_ff[`FTH_KEEP_SPIN3_BIT]; // R12

	// any channel in override takes all three fans; nothing masks it
	assign any_ovr = |ovr_ff; // R16

	// run state is per channel; fan 1 follows remote 1, fan 2 local, fan 3 remote 2
	assign nxt_drive1 = fan_duty(any_ovr, run_ff[0], above_ff[0], keep_spin[0],
		I_AUTO_DUTY_1, min_duty1_ff); // R1 R4
	assign nxt_drive2 = fan_duty(any_ovr, run_ff[1], above_ff[1], keep_spin[1],
		I_AUTO_DUTY_2, min_duty2_ff); // R1 R4
	assign nxt_drive3 = fan_duty(any_ovr, run_ff[2], above_ff[2], keep_spin[2],
		I_AUTO_DUTY_3, min_duty3_ff); // R1 R4

	// status: override flags in 2:0, run flags in 5:3, top bits read as zero
	assign status_word = {2'h0, run_ff, ovr_ff};

	// flags move only on a new reading; between readings they hold
	always @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			ovr_ff <= 3'h0;
		else if (I_TEMP_VALID)
			ovr_ff <= nxt_ovr; // R16
	end

	always @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			run_ff <= 3'h0;
		else if (I_TEMP_VALID)
			run_ff <= nxt_run; // R10
	end

	always @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			above_ff <= 3'h0;
		else if (I_TEMP_VALID)
			above_ff <= nxt_above; // R14
	end

	// drives are registered, so they trail the flags by one clock
	always @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			drive1_ff <= `FTH_DUTY_OFF;
			drive2_ff <= `FTH_DUTY_OFF;
			drive3_ff <= `FTH_DUTY_OFF;
		end
		else
		begin
			drive1_ff <= nxt_drive1; // R1 R12
			drive2_ff <= nxt_drive2; // R1 R12
			drive3_ff <= nxt_drive3; // R1 R12
		end
	end

	always @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			keep_spin_ff   <= `FTH_KEEP_SPIN_RST;
			crit_r1_ff     <= `FTH_CRIT_RST; // R5
			crit_loc_ff    <= `FTH_CRIT_RST; // R5
			crit_r2_ff     <= `FTH_CRIT_RST; // R5
			hyst_r1_loc_ff <= `FTH_R1_LOC_HYST_RST; // R3
			hyst_r2_ff     <= `FTH_R2_HYST_RST; // R3
			fan_on_r1_ff   <= `FTH_FAN_ON_RST;
			fan_on_loc_ff  <= `FTH_FAN_ON_RST;
			fan_on_r2_ff   <= `FTH_FAN_ON_RST;
			min_duty1_ff   <= `FTH_MIN_DUTY_RST;
			min_duty2_ff   <= `FTH_MIN_DUTY_RST;
			min_duty3_ff   <= `FTH_MIN_DUTY_RST;
		end
		// status and unmapped addresses match no branch, so writes there are lost
		else if (I_WR)
		begin
			if (I_ADDR == `FTH_ADDR_KEEP_SPIN)
				keep_spin_ff <= I_WDATA;
			else if (I_ADDR == `FTH_ADDR_R1_CRIT)
				crit_r1_ff <= I_WDATA;
			else if (I_ADDR == `FTH_ADDR_LOC_CRIT)
				crit_loc_ff <= I_WDATA;
			else if (I_ADDR == `FTH_ADDR_R2_CRIT)
				crit_r2_ff <= I_WDATA;
			else if (I_ADDR == `FTH_ADDR_R1_LOC_HYST)
				hyst_r1_loc_ff <= I_WDATA;
			else if (I_ADDR == `FTH_ADDR_R2_HYST)
				hyst_r2_ff <= I_WDATA;
			else if (I_ADDR == `FTH_ADDR_R1_FAN_ON)
				fan_on_r1_ff <= I_WDATA;
			else if (I_ADDR == `FTH_ADDR_LOC_FAN_ON)
				fan_on_loc_ff <= I_WDATA;
			else if (I_ADDR == `FTH_ADDR_R2_FAN_ON)
				fan_on_r2_ff <= I_WDATA;
			else if (I_ADDR == `FTH_ADDR_MIN_DUTY1)
				min_duty1_ff <= I_WDATA;
			else if (I_ADDR == `FTH_ADDR_MIN_DUTY2)
				min_duty2_ff <= I_WDATA;
			else if (I_ADDR == `FTH_ADDR_MIN_DUTY3)
				min_duty3_ff <= I_WDATA;
		end
	end

	// unmapped addresses read as zero
	always @*
	begin
		nxt_rdata = 8'h00;
		if (I_ADDR == `FTH_ADDR_KEEP_SPIN)
			nxt_rdata = keep_spin_ff;
		else if (I_ADDR == `FTH_ADDR_R1_CRIT)
			nxt_rdata = crit_r1_ff;
		else if (I_ADDR == `FTH_ADDR_LOC_CRIT)
			nxt_rdata = crit_loc_ff;
		else if (I_ADDR == `FTH_ADDR_R2_CRIT)
			nxt_rdata = crit_r2_ff;
		else if (I_ADDR == `FTH_ADDR_R1_LOC_HYST)
			nxt_rdata = hyst_r1_loc_ff;
		else if (I_ADDR == `FTH_ADDR_R2_HYST)
			nxt_rdata = hyst_r2_ff;
		else if (I_ADDR == `FTH_ADDR_STATUS)
			nxt_rdata = status_word; // R16
		else if (I_ADDR == `FTH_ADDR_R1_FAN_ON)
			nxt_rdata = fan_on_r1_ff;
		else if (I_ADDR == `FTH_ADDR_LOC_FAN_ON)
			nxt_rdata = fan_on_loc_ff;
		else if (I_ADDR == `FTH_ADDR_R2_FAN_ON)
			nxt_rdata = fan_on_r2_ff;
		else if (I_ADDR == `FTH_ADDR_MIN_DUTY1)
			nxt_rdata = min_duty1_ff;
		else if (I_ADDR == `FTH_ADDR_MIN_DUTY2)
			nxt_rdata = min_duty2_ff;
		else if (I_ADDR == `FTH_ADDR_MIN_DUTY3)
			nxt_rdata = min_duty3_ff;
	end

	// read data is held until the next read strobe
	always @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			rdata_ff <= 8'h00;
		else if (I_RD)
			rdata_ff <= nxt_rdata;
	end

	assign O_RDATA       = rdata_ff;
	assign O_FAN_DRIVE_1 = drive1_ff;
	assign O_FAN_DRIVE_2 = drive2_ff;
	assign O_FAN_DRIVE_3 = drive3_ff;
	assign O_OVERRIDE    = any_ovr;

endmodule

// File: verif/fth_override_props.sv
// concurrent checks on the ports of the thermal override block
`timescale 1ns/1ps
module fth_override_props
(
	input wire       I_CLK,
	input wire       I_RST_N,
	input wire [7:0] I_ADDR,
	input wire [7:0] I_WDATA,
	input wire       I_WR,
	input wire       I_RD,
	input wire [7:0] O_RDATA,
	input wire [7:0] I_TEMP_R1,
	input wire [7:0] I_TEMP_LOC,
	input wire [7:0] I_TEMP_R2,
	input wire       I_TEMP_VALID,
	input wire [7:0] I_AUTO_DUTY_1,
	input wire [7:0] I_AUTO_DUTY_2,
	input wire [7:0] I_AUTO_DUTY_3,
	input wire [7:0] O_FAN_DRIVE_1,
	input wire [7:0] O_FAN_DRIVE_2,
	input wire [7:0] O_FAN_DRIVE_3,
	input wire       O_OVERRIDE
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// 0xff beats any limit the bench programs
	sequence hot_s;
		I_TEMP_VALID && (I_TEMP_LOC == 8'hff);
	endsequence
	sequence cold_s;
		I_TEMP_VALID && (I_TEMP_R1 == 8'h00) && (I_TEMP_LOC == 8'h00) && (I_TEMP_R2 == 8'h00);
	endsequence
	sequence lim_wr_s;
		I_WR && (I_ADDR == 8'h6b) ##1 !I_WR ##1 I_RD && (I_ADDR == 8'h6b);
	endsequence
	hot_sets_ovr_a: assert property (hot_s |=> O_OVERRIDE)
		else $error("override not raised by hot reading");
	ovr_full_duty_a: assert property (O_OVERRIDE |=> (O_FAN_DRIVE_1 == 8'hff)
		&& (O_FAN_DRIVE_2 == 8'hff) && (O_FAN_DRIVE_3 == 8'hff)) else $error("drive not full");
	ovr_hold_a: assert property (!I_TEMP_VALID |=> $stable(O_OVERRIDE))
		else $error("override moved without reading");
	cold_clears_a: assert property (cold_s |=> !O_OVERRIDE)
		else $error("override kept on cold reading");
	rdata_hold_a: assert property (!I_RD |=> $stable(O_RDATA)) else $error("read data moved");
	unmapped_zero_a: assert property (I_RD && (I_ADDR == 8'h00) |=> O_RDATA == 8'h00)
		else $error("unmapped read not zero");
	status_ovr_a: assert property (I_RD && (I_ADDR == 8'h70) |=>
		((|O_RDATA[2:0]) == $past(O_OVERRIDE)) && (O_RDATA[7:6] == 2'b00))
		else $error("status disagrees with override");
	limit_readback_a: assert property (lim_wr_s |=> O_RDATA == $past(I_WDATA, 3))
		else $error("limit readback wrong");
endmodule

bind fth_override fth_override_props u_fth_override_props
(
	.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
	.I_RD(I_RD), .O_RDATA(O_RDATA), .I_TEMP_R1(I_TEMP_R1), .I_TEMP_LOC(I_TEMP_LOC),
	.I_TEMP_R2(I_TEMP_R2), .I_TEMP_VALID(I_TEMP_VALID), .I_AUTO_DUTY_1(I_AUTO_DUTY_1),
	.I_AUTO_DUTY_2(I_AUTO_DUTY_2), .I_AUTO_DUTY_3(I_AUTO_DUTY_3), .O_FAN_DRIVE_1(O_FAN_DRIVE_1),
	.O_FAN_DRIVE_2(O_FAN_DRIVE_2), .O_FAN_DRIVE_3(O_FAN_DRIVE_3), .O_OVERRIDE(O_OVERRIDE)
);

// File: verif/fth_override_tb.sv
// self-checking bench for the thermal override block
`timescale 1ns/1ps
module fth_override_tb;
	reg        clk = 1'b0;
	reg        rst_n = 1'b0;
	reg  [7:0] addr = 8'h00;
	reg  [7:0] wdata = 8'h00;
	reg        wr_stb = 1'b0;
	reg        rd_stb = 1'b0;
	reg  [7:0] t_r1 = 8'h00;
	reg  [7:0] t_loc = 8'h00;
	reg  [7:0] t_r2 = 8'h00;
	reg        tvalid = 1'b0;
	wire [7:0] rdata;
	wire [7:0] drv1;
	wire [7:0] drv2;
	wire [7:0] drv3;
	wire       ovr;
	integer    mismatches = 0;
	integer    samples_checked = 0;
	integer    i;
	reg [15:0] rows [0:7];
	fth_override u_fth_override
	(
		.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_stb),
		.I_RD(rd_stb), .O_RDATA(rdata), .I_TEMP_R1(t_r1), .I_TEMP_LOC(t_loc), .I_TEMP_R2(t_r2),
		.I_TEMP_VALID(tvalid), .I_AUTO_DUTY_1(8'h31), .I_AUTO_DUTY_2(8'h32),
		.I_AUTO_DUTY_3(8'h33), .O_FAN_DRIVE_1(drv1), .O_FAN_DRIVE_2(drv2),
		.O_FAN_DRIVE_3(drv3), .O_OVERRIDE(ovr)
	);
	initial
	begin
		forever #50 clk = ~clk;
	end
	task automatic check(input string name, input [7:0] exp, input [7:0] got);
		samples_checked = samples_checked + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic bus_wr(input [7:0] a, input [7:0] d);
		@(posedge clk) {addr, wdata, wr_stb} <= {a, d, 1'b1};
		@(posedge clk) wr_stb <= 1'b0;
	endtask
	task automatic bus_rd(input [7:0] a, input [7:0] exp);
		@(posedge clk) {addr, rd_stb} <= {a, 1'b1};
		@(posedge clk) rd_stb <= 1'b0;
		#1 check("read data", exp, rdata);
	endtask
	// drives settle one edge after the flags, so look two edges on
	task automatic reading(input [7:0] r1, input [7:0] lc, input [7:0] r2, input eo);
		@(posedge clk) {t_r1, t_loc, t_r2, tvalid} <= {r1, lc, r2, 1'b1};
		@(posedge clk) tvalid <= 1'b0;
		@(posedge clk) #1 check("override", {7'h00, eo}, {7'h00, ovr});
	endtask
	task automatic drives(input [7:0] e1, input [7:0] e2, input [7:0] e3);
		check("fan drive 1", e1, drv1);
		check("fan drive 2", e2, drv2);
		check("fan drive 3", e3, drv3);
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		// run is some 110 cycles; allow over eighteen times that
		#(2000 * 100);
		mismatches = mismatches + 1;
		complete_run;
	end
	initial
	begin
		rows = '{16'h6aa4, 16'h6ba4, 16'h6ca4, 16'h6d44, 16'h6e40, 16'h6200, 16'h0000, 16'h7000};
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 8; i = i + 1)
			bus_rd(rows[i][15:8], rows[i][7:0]);
		drives(8'h00, 8'h00, 8'h00);
		$display("reset values done");
		bus_wr(8'h6d, 8'h21);
		bus_wr(8'h6a, 8'h90);
		bus_rd(8'h6d, 8'h21);
		reading(8'h91, 8'h20, 8'h20, 1'b1);
		drives(8'hff, 8'hff, 8'hff);
		bus_rd(8'h70, 8'h09);
		reading(8'h8e, 8'h20, 8'h20, 1'b1);
		reading(8'h8d, 8'h20, 8'h20, 1'b0);
		drives(8'h31, 8'h00, 8'h00);
		reading(8'h20, 8'ha4, 8'h20, 1'b0);
		drives(8'h00, 8'h32, 8'h00);
		reading(8'h20, 8'hff, 8'h20, 1'b1);
		reading(8'h00, 8'h00, 8'h00, 1'b0);
		$display("override done");
		bus_wr(8'h62, 8'ha0);
		bus_wr(8'h76, 8'h47);
		reading(8'h10, 8'h10, 8'h10, 1'b0);
		drives(8'h80, 8'h00, 8'h47);
		reading(8'h5b, 8'h5b, 8'h5b, 1'b0);
		drives(8'h31, 8'h32, 8'h33);
		reading(8'h5a, 8'h5a, 8'h5a, 1'b0);
		drives(8'h80, 8'h32, 8'h47);
		reading(8'h55, 8'h55, 8'h55, 1'b0);
		drives(8'h80, 8'h00, 8'h47);
		$display("fan on hysteresis done");
		bus_wr(8'h6e, 8'h00);
		reading(8'h00, 8'h00, 8'ha5, 1'b1);
		reading(8'h00, 8'h00, 8'ha3, 1'b0);
		bus_wr(8'h6e, 8'hf0);
		reading(8'h00, 8'h00, 8'ha5, 1'b1);
		reading(8'h00, 8'h00, 8'h95, 1'b1);
		reading(8'h00, 8'h00, 8'h94, 1'b0);
		bus_wr(8'h70, 8'hff);
		bus_wr(8'h00, 8'h55);
		bus_rd(8'h00, 8'h00);
		bus_rd(8'h70, 8'h20);
		bus_wr(8'h6b, 8'h77);
		bus_rd(8'h6b, 8'h77);
		$display("hysteresis range and map done");
		reading(8'hff, 8'h00, 8'h00, 1'b1);
		@(posedge clk) rst_n <= 1'b0;
		@(posedge clk) #1 check("override", 8'h00, {7'h00, ovr});
		drives(8'h00, 8'h00, 8'h00);
		@(posedge clk) rst_n <= 1'b1;
		bus_rd(8'h6a, 8'ha4);
		$display("mid-run reset done");
		complete_run;
	end
endmodule
